// [rtl/ppmc_top.v]
// Purpose: Open-drain and input threshold mode control for ports 2,3,4,6,7,8.
// Assumes: Register bus on CLOCK; EXT_SPACE high selects the extended register space.
// Notes: Short addresses are upper byte zero; the full address is base plus twice the value.
`timescale 1ns/1ps
`include "ppmc_defines.vh"

// What this block does
// - Every open-drain bit clears at reset, so lines start push-pull.
// - An open-drain bit at one puts that line's driver in open-drain mode.
// - In open-drain mode the high-side driver stays off at all times.
// - Open-drain line with latch at one turns low side off too; pin floats.
// - One open-drain bit per line for ports 2, 3, 4, 6, 7 and 8.
// - Open-drain registers live only in the extended register space.
// - Threshold select per byte: one bit for 8-bit ports 4, 7 and 8, two for 16-bit; port 6 has none.
// - Low-byte select: zero gives TTL levels on pins 7..0, one gives hysteresis.
// - High-byte select: zero gives TTL levels on pins 15..8, one gives hysteresis.
// - Threshold register answers at 0xF1C4 and at short address E2h.
// - Direction and open-drain control work regardless of threshold setting.
module ppmc_top (
	input wire CLOCK,
	input wire SRST,
	input wire [`PPMC_AW-1:0] ADDR,
	input wire [`PPMC_DW-1:0] WDATA,
	input wire WR,
	input wire RD,
	input wire EXT_SPACE,
	output reg [`PPMC_DW-1:0] RDATA,
	input wire [15:0] P2_LATCH,
	input wire [15:0] P2_DIR,
	input wire [15:0] P2_PAD_IN,
	output wire [15:0] P2_HI_EN,
	output wire [15:0] P2_LO_EN,
	output wire [15:0] P2_OE_N,
	output wire [15:0] P2_PAD_OUT,
	output wire [15:0] P2_DIN,
	output wire [1:0] P2_HYST,
	input wire [15:0] P3_LATCH,
	input wire [15:0] P3_DIR,
	input wire [15:0] P3_PAD_IN,
	output wire [15:0] P3_HI_EN,
	output wire [15:0] P3_LO_EN,
	output wire [15:0] P3_OE_N,
	output wire [15:0] P3_PAD_OUT,
	output wire [15:0] P3_DIN,
	output wire [1:0] P3_HYST,
	input wire [7:0] P4_LATCH,
	input wire [7:0] P4_DIR,
	input wire [7:0] P4_PAD_IN,
	output wire [7:0] P4_HI_EN,
	output wire [7:0] P4_LO_EN,
	output wire [7:0] P4_OE_N,
	output wire [7:0] P4_PAD_OUT,
	output wire [7:0] P4_DIN,
	output wire P4_HYST,
	input wire [7:0] P6_LATCH,
	input wire [7:0] P6_DIR,
	input wire [7:0] P6_PAD_IN,
	output wire [7:0] P6_HI_EN,
	output wire [7:0] P6_LO_EN,
	output wire [7:0] P6_OE_N,
	output wire [7:0] P6_PAD_OUT,
	output wire [7:0] P6_DIN,
	input wire [7:0] P7_LATCH,
	input wire [7:0] P7_DIR,
	input wire [7:0] P7_PAD_IN,
	output wire [7:0] P7_HI_EN,
	output wire [7:0] P7_LO_EN,
	output wire [7:0] P7_OE_N,
	output wire [7:0] P7_PAD_OUT,
	output wire [7:0] P7_DIN,
	output wire P7_HYST,
	input wire [7:0] P8_LATCH,
	input wire [7:0] P8_DIR,
	input wire [7:0] P8_PAD_IN,
	output wire [7:0] P8_HI_EN,
	output wire [7:0] P8_LO_EN,
	output wire [7:0] P8_OE_N,
	output wire [7:0] P8_PAD_OUT,
	output wire [7:0] P8_DIN,
	output wire P8_HYST
);

////////////////////////////////////////////////////////////////////////////////
// Control registers
reg [15:0] od2_ff;
reg [15:0] od3_ff;
reg [7:0] od4_ff;
reg [7:0] od6_ff;
reg [7:0] od7_ff;
reg [7:0] od8_ff;
reg [15:0] thr_ff;
reg [`PPMC_DW-1:0] nxt_rdata;
wire [`PPMC_AW-1:0] eff_addr;
wire short_form;
wire wr_ok;
wire hit_od2;
wire hit_od3;
wire hit_od4;
wire hit_od6;
wire hit_od7;
wire hit_od8;
wire hit_thr;

////////////////////////////////////////////////////////////////////////////////
// Address normalisation: short form maps onto the same full address
assign short_form = (ADDR[15:8] == `PPMC_SHORT_PAGE);
assign eff_addr = short_form ? {`PPMC_SHORT_BASE, `PPMC_SHORT_PAD, ADDR[7:0], 1'b0} :
	ADDR;
// Only the extended space carries these registers
assign wr_ok = WR & EXT_SPACE;
// Register hits on the normalised address
assign hit_od2 = (eff_addr == `PPMC_ADDR_OD2);
assign hit_od3 = (eff_addr == `PPMC_ADDR_OD3);
assign hit_od4 = (eff_addr == `PPMC_ADDR_OD4);
assign hit_od6 = (eff_addr == `PPMC_ADDR_OD6);
assign hit_od7 = (eff_addr == `PPMC_ADDR_OD7);
assign hit_od8 = (eff_addr == `PPMC_ADDR_OD8);
assign hit_thr = (eff_addr == `PPMC_ADDR_THR);

////////////////////////////////////////////////////////////////////////////////
// Register writes; each register takes the bus only on its own hit,
// so a write to an unmapped address changes nothing
// Port 2 open-drain bits
always @(posedge CLOCK)
begin
	if (SRST)
		od2_ff <= `PPMC_OD16_RST;
	else if (wr_ok && hit_od2)
		od2_ff <= WDATA;
end

// Port 3 open-drain bits
always @(posedge CLOCK)
begin
	if (SRST)
		od3_ff <= `PPMC_OD16_RST;
	else if (wr_ok && hit_od3)
		od3_ff <= WDATA;
end

// Port 4 open-drain bits; only the low byte exists
always @(posedge CLOCK)
begin
	if (SRST)
		od4_ff <= `PPMC_OD8_RST;
	else if (wr_ok && hit_od4)
		od4_ff <= WDATA[7:0];
end

// Port 6 open-drain bits; only the low byte exists
always @(posedge CLOCK)
begin
	if (SRST)
		od6_ff <= `PPMC_OD8_RST;
	else if (wr_ok && hit_od6)
		od6_ff <= WDATA[7:0];
end

// Port 7 open-drain bits; only the low byte exists
always @(posedge CLOCK)
begin
	if (SRST)
		od7_ff <= `PPMC_OD8_RST;
	else if (wr_ok && hit_od7)
		od7_ff <= WDATA[7:0];
end

// Port 8 open-drain bits; only the low byte exists
always @(posedge CLOCK)
begin
	if (SRST)
		od8_ff <= `PPMC_OD8_RST;
	else if (wr_ok && hit_od8)
		od8_ff <= WDATA[7:0];
end

// Threshold selects; masking keeps unused bits at zero so they can never read back one
always @(posedge CLOCK)
begin
	if (SRST)
		thr_ff <= `PPMC_THR_RST;
	else if (wr_ok && hit_thr)
		thr_ff <= WDATA & `PPMC_THR_MASK;
end

////////////////////////////////////////////////////////////////////////////////
// Read mux; narrow registers read zero in the upper byte and unmapped space reads zero
always @*
begin
	nxt_rdata = `PPMC_RD_IDLE;
	if (RD && EXT_SPACE)
	begin
		case (eff_addr)
		`PPMC_ADDR_OD2: nxt_rdata = od2_ff;
		`PPMC_ADDR_OD3: nxt_rdata = od3_ff;
		`PPMC_ADDR_OD4: nxt_rdata = {`PPMC_BYTE_ZERO, od4_ff};
		`PPMC_ADDR_OD6: nxt_rdata = {`PPMC_BYTE_ZERO, od6_ff};
		`PPMC_ADDR_OD7: nxt_rdata = {`PPMC_BYTE_ZERO, od7_ff};
		`PPMC_ADDR_OD8: nxt_rdata = {`PPMC_BYTE_ZERO, od8_ff};
		`PPMC_ADDR_THR: nxt_rdata = thr_ff & `PPMC_THR_MASK;
		default: nxt_rdata = `PPMC_RD_IDLE;
		endcase
	end
end

// Read data stands only in the cycle after the strobe
always @(posedge CLOCK)
begin
	if (SRST)
		RDATA <= `PPMC_RD_IDLE;
	else
		RDATA <= nxt_rdata;
end

////////////////////////////////////////////////////////////////////////////////
// Port 2: 16 lines, two byte threshold selects
ppmc_pad_port #(.W(16), .NB(2)) u_port2 (
	.clk(CLOCK),
	.srst(SRST),
	.latch(P2_LATCH),
	.dir(P2_DIR),
	.od(od2_ff),
	.thr_sel({thr_ff[`PPMC_THR_P2H], thr_ff[`PPMC_THR_P2L]}),
	.pad_in(P2_PAD_IN),
	.hi_en_ff(P2_HI_EN),
	.lo_en_ff(P2_LO_EN),
	.oe_n_ff(P2_OE_N),
	.pad_out_ff(P2_PAD_OUT),
	.din_ff(P2_DIN),
	.thr_ff(P2_HYST)
);

// Port 3: 16 lines, two byte threshold selects
ppmc_pad_port #(.W(16), .NB(2)) u_port3 (
	.clk(CLOCK),
	.srst(SRST),
	.latch(P3_LATCH),
	.dir(P3_DIR),
	.od(od3_ff),
	.thr_sel({thr_ff[`PPMC_THR_P3H], thr_ff[`PPMC_THR_P3L]}),
	.pad_in(P3_PAD_IN),
	.hi_en_ff(P3_HI_EN),
	.lo_en_ff(P3_LO_EN),
	.oe_n_ff(P3_OE_N),
	.pad_out_ff(P3_PAD_OUT),
	.din_ff(P3_DIN),
	.thr_ff(P3_HYST)
);

// Port 4: 8 lines, one threshold select
ppmc_pad_port #(.W(8), .NB(1)) u_port4 (
	.clk(CLOCK),
	.srst(SRST),
	.latch(P4_LATCH),
	.dir(P4_DIR),
	.od(od4_ff),
	.thr_sel(thr_ff[`PPMC_THR_P4L]),
	.pad_in(P4_PAD_IN),
	.hi_en_ff(P4_HI_EN),
	.lo_en_ff(P4_LO_EN),
	.oe_n_ff(P4_OE_N),
	.pad_out_ff(P4_PAD_OUT),
	.din_ff(P4_DIN),
	.thr_ff(P4_HYST)
);

// Port 6: 8 lines, open-drain only; it has no threshold choice
ppmc_pad_port #(.W(8), .NB(1)) u_port6 (
	.clk(CLOCK),
	.srst(SRST),
	.latch(P6_LATCH),
	.dir(P6_DIR),
	.od(od6_ff),
	.thr_sel(1'b0),
	.pad_in(P6_PAD_IN),
	.hi_en_ff(P6_HI_EN),
	.lo_en_ff(P6_LO_EN),
	.oe_n_ff(P6_OE_N),
	.pad_out_ff(P6_PAD_OUT),
	.din_ff(P6_DIN),
	.thr_ff()
);

// Port 7: 8 lines, one threshold select
ppmc_pad_port #(.W(8), .NB(1)) u_port7 (
	.clk(CLOCK),
	.srst(SRST),
	.latch(P7_LATCH),
	.dir(P7_DIR),
	.od(od7_ff),
	.thr_sel(thr_ff[`PPMC_THR_P7L]),
	.pad_in(P7_PAD_IN),
	.hi_en_ff(P7_HI_EN),
	.lo_en_ff(P7_LO_EN),
	.oe_n_ff(P7_OE_N),
	.pad_out_ff(P7_PAD_OUT),
	.din_ff(P7_DIN),
	.thr_ff(P7_HYST)
);

// Port 8: 8 lines, one threshold select
ppmc_pad_port #(.W(8), .NB(1)) u_port8 (
	.clk(CLOCK),
	.srst(SRST),
	.latch(P8_LATCH),
	.dir(P8_DIR),
	.od(od8_ff),
	.thr_sel(thr_ff[`PPMC_THR_P8L]),
	.pad_in(P8_PAD_IN),
	.hi_en_ff(P8_HI_EN),
	.lo_en_ff(P8_LO_EN),
	.oe_n_ff(P8_OE_N),
	.pad_out_ff(P8_PAD_OUT),
	.din_ff(P8_DIN),
	.thr_ff(P8_HYST)
);

endmodule // ppmc_top

// [rtl/ppmc_defines.vh]
// Purpose: Shared constants for the port pad mode control block.
// Assumes: 16-bit register bus, extended register space selected by a flag.
// Notes: Definitions only; included by bare name.
`ifndef PPMC_DEFINES_VH
`define PPMC_DEFINES_VH

// Bus widths
`define PPMC_AW 16
`define PPMC_DW 16

// Full addresses in the extended register space
`define PPMC_ADDR_THR 16'hf1c4
`define PPMC_ADDR_OD2 16'hf1c2
`define PPMC_ADDR_OD3 16'hf1c6
`define PPMC_ADDR_OD4 16'hf1ca
`define PPMC_ADDR_OD6 16'hf1ce
`define PPMC_ADDR_OD7 16'hf1d2
`define PPMC_ADDR_OD8 16'hf1d6

// Short address form: upper byte zero, full address is base plus twice the short value
`define PPMC_SHORT_PAGE 8'h00
`define PPMC_SHORT_BASE 4'hf
`define PPMC_SHORT_PAD 3'h0

// Threshold select field positions
`define PPMC_THR_P2L 0
`define PPMC_THR_P2H 1
`define PPMC_THR_P3L 2
`define PPMC_THR_P3H 3
`define PPMC_THR_P4L 4
`define PPMC_THR_P7L 5
`define PPMC_THR_P8L 6
`define PPMC_THR_MASK 16'h007f

// Reset values
`define PPMC_THR_RST 16'h0000
`define PPMC_OD16_RST 16'h0000
`define PPMC_OD8_RST 8'h00
`define PPMC_RD_IDLE 16'h0000
`define PPMC_BYTE_ZERO 8'h00

`endif

// [rtl/ppmc_pad_port.v]
// Purpose: Output driver and input conditioning for one parallel port.
// Assumes: Latch, direction and mode inputs come from logic on the same clock.
// Notes: All outputs are registered, so pad controls lag their sources by one cycle.
`timescale 1ns/1ps
module ppmc_pad_port #(
	parameter W = 8,
	parameter NB = 1
) (
	input wire clk,
	input wire srst,
	input wire [W-1:0] latch,
	input wire [W-1:0] dir,
	input wire [W-1:0] od,
	input wire [NB-1:0] thr_sel,
	input wire [W-1:0] pad_in,
	output reg [W-1:0] hi_en_ff,
	output reg [W-1:0] lo_en_ff,
	output reg [W-1:0] oe_n_ff,
	output reg [W-1:0] pad_out_ff,
	output reg [W-1:0] din_ff,
	output reg [NB-1:0] thr_ff
);

reg [W-1:0] sync1_ff;
wire [W-1:0] nxt_hi_en;
wire [W-1:0] nxt_lo_en;

////////////////////////////////////////////////////////////////////////////////
// Driver decode; direction and mode work whatever the threshold select is
assign nxt_hi_en = dir & ~od & latch;
assign nxt_lo_en = dir & ~latch;

////////////////////////////////////////////////////////////////////////////////
// Registered pad controls; reset leaves every driver off
always @(posedge clk)
begin
	if (srst)
	begin
		hi_en_ff <= {W{1'b0}};
		lo_en_ff <= {W{1'b0}};
		oe_n_ff <= {W{1'b1}};
		pad_out_ff <= {W{1'b0}};
		thr_ff <= {NB{1'b0}};
	end
	else
	begin
		hi_en_ff <= nxt_hi_en;
		lo_en_ff <= nxt_lo_en;
		oe_n_ff <= ~(nxt_hi_en | nxt_lo_en); // Released pin reads as undriven
		pad_out_ff <= nxt_hi_en; // Low whenever only the low side may act
		thr_ff <= thr_sel;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Two-stage synchroniser for pin levels; first stage feeds only the second
always @(posedge clk)
begin
	if (srst)
	begin
		sync1_ff <= {W{1'b0}};
		din_ff <= {W{1'b0}};
	end
	else
	begin
		sync1_ff <= pad_in;
		din_ff <= sync1_ff;
	end
end

endmodule // ppmc_pad_port

// [verification/ppmc_pullup_line.sv]
// Purpose: Wired-AND line model with an external pull-up for one port.
// Assumes: oe_n low means the block drives pad_out onto the line.
// Notes: Any party pulling low wins; a released line rises through the pull-up.
`timescale 1ns/1ps
module ppmc_pullup_line (
	input wire [15:0] oe_n,
	input wire [15:0] pad_out,
	input wire [15:0] ext_low,
	output wire [15:0] pad
);
	// A driven high loses to an external low, as on a real shared line
	assign pad = (pad_out | oe_n) & ~ext_low;
endmodule // ppmc_pullup_line

// [verification/ppmc_top_asserts.sv]
// Purpose: Port-level checks of pad decode and register bus for the pad mode block.
// Assumes: Only port 2 pads and the bus are watched; other ports share the same slice.
// Notes: Checks right after reset use $past guards because pads lag inputs by one edge.
`timescale 1ns/1ps
`include "ppmc_defines.vh"
module ppmc_top_chk (
	input wire CLOCK,
	input wire SRST,
	input wire [15:0] ADDR,
	input wire [15:0] WDATA,
	input wire WR,
	input wire RD,
	input wire EXT_SPACE,
	input wire [15:0] RDATA,
	input wire [15:0] P2_LATCH,
	input wire [15:0] P2_DIR,
	input wire [15:0] P2_HI_EN,
	input wire [15:0] P2_LO_EN,
	input wire [15:0] P2_OE_N,
	input wire [15:0] P2_PAD_OUT,
	input wire [1:0] P2_HYST
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (SRST);
	////////////////////////////////////////////////////////////////////////////////
	// Threshold register accesses: writes by full address only, reads by full or short address
	sequence s_thr_wr;
		WR && EXT_SPACE && ADDR == `PPMC_ADDR_THR;
	endsequence
	sequence s_thr_rd;
		RD && EXT_SPACE && (ADDR == `PPMC_ADDR_THR || ADDR == 16'h00e2);
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	// Bus-side copy of the port 2 open-drain bits, built from writes alone
	logic [15:0] od2_mdl;
	wire [15:0] od_rel;
	always @(posedge CLOCK)
	begin
		if (SRST)
			od2_mdl <= 16'h0000;
		else if (WR && EXT_SPACE && (ADDR == `PPMC_ADDR_OD2 || ADDR == 16'h00e1))
			od2_mdl <= WDATA;
	end
	// Lines that must float: open-drain with latch at one
	assign od_rel = od2_mdl & P2_LATCH;
	////////////////////////////////////////////////////////////////////////////////
	// Reset must be seen even while reset holds, hence no disable here
	a_reset_pads: assert property (disable iff (1'b0) SRST |=>
		P2_OE_N == 16'hffff && P2_HI_EN == 16'h0000)
		else $error("pads not released after reset");
	a_hi_cause: assert property (!$past(SRST) |->
		(P2_HI_EN & ~$past(P2_DIR & P2_LATCH)) == 16'h0000)
		else $error("high side on without output latch one");
	a_od_high: assert property (!$past(SRST) |-> (P2_HI_EN & $past(od2_mdl)) == 16'h0000)
		else $error("high side on for an open-drain line");
	a_od_float: assert property (!$past(SRST) |-> (P2_OE_N & $past(od_rel)) == $past(od_rel))
		else $error("open-drain line with latch one not released");
	a_lo_follow: assert property (!$past(SRST) |->
		P2_LO_EN == $past(P2_DIR & ~P2_LATCH))
		else $error("low side does not follow latch zero");
	a_drive_pair: assert property (
		P2_OE_N == ~(P2_HI_EN | P2_LO_EN) && P2_PAD_OUT == P2_HI_EN)
		else $error("pin release does not match drivers");
	a_ext_refused: assert property ($past(RD && !EXT_SPACE) |-> RDATA == 16'h0000)
		else $error("read outside extended space answered");
	a_thr_upper: assert property (s_thr_rd |=> RDATA[15:7] == 9'h000)
		else $error("unused threshold bits read nonzero");
	a_thr_hyst: assert property (s_thr_wr |-> ##2 P2_HYST == $past(WDATA[1:0], 2))
		else $error("port 2 threshold outputs wrong after write");
	a_thr_back: assert property (s_thr_wr ##1 !WR ##1 s_thr_rd |=>
		RDATA[6:0] == $past(WDATA[6:0], 3))
		else $error("threshold readback wrong");
endmodule // ppmc_top_chk
bind ppmc_top ppmc_top_chk ppmc_top_chk_i (.CLOCK(CLOCK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA),
	.WR(WR), .RD(RD), .EXT_SPACE(EXT_SPACE), .RDATA(RDATA), .P2_LATCH(P2_LATCH), .P2_DIR(P2_DIR),
	.P2_HI_EN(P2_HI_EN), .P2_LO_EN(P2_LO_EN), .P2_OE_N(P2_OE_N), .P2_PAD_OUT(P2_PAD_OUT),
	.P2_HYST(P2_HYST));

// [verification/ppmc_top_tb.sv]
// Purpose: Self-checking bench for the pad mode block with wired-AND lines.
// Assumes: Ports indexed 0..5 stand for ports 2,3,4,6,7,8; 8-bit ports use low bytes.
// Notes: Reads are queued at the request and compared by a monitor one cycle later.
`timescale 1ns/1ps
`include "ppmc_defines.vh"
module ppmc_top_tb;
	logic clock = 0, srst = 1, wr = 0, rd = 0, ext = 0, rd_pend = 0;
	logic [15:0] addr = 0, wdata = 0, ext_low = 0, v;
	logic [15:0] lat [6], dir [6], od [6];
	wire [15:0] pin [6], hi [6], lo [6], oen [6], po [6], din [6], rdata;
	wire [6:0] hys;
	logic [15:0] exp_q [$];
	logic [15:0] regs [7] = '{`PPMC_ADDR_THR, `PPMC_ADDR_OD2, `PPMC_ADDR_OD3, `PPMC_ADDR_OD4,
		`PPMC_ADDR_OD6, `PPMC_ADDR_OD7, `PPMC_ADDR_OD8};
	int error_cnt = 0, comparisons = 0;
	////////////////////////////////////////////////////////////////////////////////
	ppmc_top ppmc_top_i (.CLOCK(clock), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.EXT_SPACE(ext), .RDATA(rdata),
		.P2_LATCH(lat[0]), .P2_DIR(dir[0]), .P2_PAD_IN(pin[0]), .P2_HI_EN(hi[0]), .P2_LO_EN(lo[0]),
		.P2_OE_N(oen[0]), .P2_PAD_OUT(po[0]), .P2_DIN(din[0]), .P2_HYST(hys[1:0]),
		.P3_LATCH(lat[1]), .P3_DIR(dir[1]), .P3_PAD_IN(pin[1]), .P3_HI_EN(hi[1]), .P3_LO_EN(lo[1]),
		.P3_OE_N(oen[1]), .P3_PAD_OUT(po[1]), .P3_DIN(din[1]), .P3_HYST(hys[3:2]),
		.P4_LATCH(lat[2][7:0]), .P4_DIR(dir[2][7:0]), .P4_PAD_IN(pin[2][7:0]), .P4_HYST(hys[4]),
		.P4_HI_EN(hi[2][7:0]), .P4_LO_EN(lo[2][7:0]), .P4_OE_N(oen[2][7:0]),
		.P4_PAD_OUT(po[2][7:0]), .P4_DIN(din[2][7:0]),
		.P6_LATCH(lat[3][7:0]), .P6_DIR(dir[3][7:0]), .P6_PAD_IN(pin[3][7:0]),
		.P6_HI_EN(hi[3][7:0]), .P6_LO_EN(lo[3][7:0]), .P6_OE_N(oen[3][7:0]),
		.P6_PAD_OUT(po[3][7:0]), .P6_DIN(din[3][7:0]),
		.P7_LATCH(lat[4][7:0]), .P7_DIR(dir[4][7:0]), .P7_PAD_IN(pin[4][7:0]), .P7_HYST(hys[5]),
		.P7_HI_EN(hi[4][7:0]), .P7_LO_EN(lo[4][7:0]), .P7_OE_N(oen[4][7:0]),
		.P7_PAD_OUT(po[4][7:0]), .P7_DIN(din[4][7:0]),
		.P8_LATCH(lat[5][7:0]), .P8_DIR(dir[5][7:0]), .P8_PAD_IN(pin[5][7:0]), .P8_HYST(hys[6]),
		.P8_HI_EN(hi[5][7:0]), .P8_LO_EN(lo[5][7:0]), .P8_OE_N(oen[5][7:0]),
		.P8_PAD_OUT(po[5][7:0]), .P8_DIN(din[5][7:0]));
	// One shared line model per port; upper bytes of 8-bit ports are unused
	for (genvar g = 0; g < 6; g++)
	begin : lines
		ppmc_pullup_line ppmc_pullup_line_i (.oe_n(oen[g]), .pad_out(po[g]), .ext_low(ext_low),
			.pad(pin[g]));
	end
	////////////////////////////////////////////////////////////////////////////////
	// Clock at 40 ns period
	initial
	begin
		forever #20 clock = ~clock;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] e);
		comparisons++;
		if (got !== e)
		begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, e);
			error_cnt++;
		end
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic bus_wr(input logic [15:0] a, input logic [15:0] d, input logic x);
		@(posedge clock);
		addr <= a; wdata <= d; ext <= x; wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	// The expected word is noted when the read is issued
	task automatic bus_rd(input logic [15:0] a, input logic [15:0] e, input logic x);
		@(posedge clock);
		addr <= a; ext <= x; rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clock);
		rd <= 1'b0;
	endtask
	// Every register reads zero by full and by short address
	task automatic regs_zero;
		for (int j = 0; j < 7; j++)
		begin
			bus_rd(regs[j], 16'h0000, 1'b1);
			bus_rd({8'h00, regs[j][8:1]}, 16'h0000, 1'b1);
		end
	endtask
	// Random latches, directions and far-side pulls; the line is low wherever anyone sinks it
	task automatic pads(input int n);
		logic [15:0] m;
		for (int k = 0; k < n; k++)
		begin
			@(posedge clock);
			for (int i = 0; i < 6; i++)
			begin
				lat[i] <= 16'($urandom);
				dir[i] <= 16'($urandom);
			end
			ext_low <= 16'($urandom & $urandom);
			repeat (5) @(posedge clock);
			for (int i = 0; i < 6; i++)
			begin
				m = (i < 2) ? 16'hffff : 16'h00ff;
				chk(hi[i] & m, dir[i] & ~od[i] & lat[i] & m);
				chk(lo[i] & m, dir[i] & ~lat[i] & m);
				chk(oen[i] & m, ~(dir[i] & ~od[i] & lat[i] | dir[i] & ~lat[i]) & m);
				chk(din[i] & m, ~(dir[i] & ~lat[i]) & ~ext_low & m);
			end
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Read monitor: the word stands only in the cycle after the strobe
	always @(posedge clock)
	begin
		rd_pend <= rd;
		if (rd_pend) chk(rdata, exp_q.pop_front());
	end
	// Hang guard
	initial
	begin
		repeat (30000) @(posedge clock);
		error_cnt++;
		complete_run;
	end
	// Main sequence
	initial
	begin
		v = 16'($urandom(32'h797d48aa));
		for (int i = 0; i < 6; i++)
		begin
			lat[i] = 0; dir[i] = 0; od[i] = 0;
		end
		repeat (12) @(posedge clock);
		srst <= 1'b0;
		regs_zero;
		pads(2);
		$display("reset test done");
		for (int i = 0; i < 6; i++)
		begin
			od[i] = 16'($urandom) & ((i < 2) ? 16'hffff : 16'h00ff);
			bus_wr(regs[i + 1], od[i], 1'b1);
			bus_wr(regs[i + 1], ~od[i], 1'b0);
			bus_rd(regs[i + 1], 16'h0000, 1'b0);
			bus_rd(regs[i + 1], od[i], 1'b1);
		end
		pads(4);
		$display("open drain test done");
		bus_wr(16'h00e2, 16'hffff, 1'b1);
		bus_rd(`PPMC_ADDR_THR, 16'h007f, 1'b1);
		chk({9'h000, hys}, 16'h007f);
		pads(3);
		for (int k = 0; k < 6; k++)
		begin
			v = 16'($urandom);
			bus_wr(`PPMC_ADDR_THR, v, 1'b1);
			bus_rd(16'h00e2, v & 16'h007f, 1'b1);
			chk({9'h000, hys}, v & 16'h007f);
		end
		bus_rd(16'hf1c0, 16'h0000, 1'b1);
		$display("threshold test done");
		@(posedge clock);
		srst <= 1'b1;
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		for (int i = 0; i < 6; i++) od[i] = 0;
		regs_zero;
		pads(1);
		$display("mid reset test done");
		repeat (3) @(posedge clock);
		chk(16'(exp_q.size()), 16'h0000);
		complete_run;
	end
endmodule // ppmc_top_tb
